// *** csb_chk.sv ***
// assertion checker for the sideband control block
`timescale 1ns/10ps
module csb_chk
   import csb_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RSTN,
   // snoop
   input wire logic SNOOP_REQ,
   input wire logic SNOOP_BUSY,
   input wire logic SNOOP_HIT_DIRTY,
   input wire logic SNOOP_HIT_IN,
   input wire logic SNOOP_DIRTY_RESULT_IN,
   input wire logic SNOOP_HIT_OE_N,
   input wire logic SNOOP_DIRTY_RESULT_OE_N,
   input wire logic SNOOP_DONE,
   input wire logic PEER_SNOOP_STALL,
   input wire logic PEER_SNOOP_VALID,
   // fault and restart
   input wire logic FAULT_DETECT,
   input wire logic BUS_RESTART_REQUEST,
   input wire logic WARM_RESTART,
   input wire logic INTERNAL_FAULT_FLAG,
   input wire logic INT_REG_CLEAR,
   input wire logic SELFTEST_RUN,
   // atomic hold
   input wire logic ATOMIC_START,
   input wire logic ATOMIC_END,
   input wire logic ATOMIC_HOLD_OE_N
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   logic restart;
   assign restart = BUS_RESTART_REQUEST | WARM_RESTART;
   // both results from the far side while this end drives neither
   sequence s_peer_both;
      SNOOP_HIT_IN && SNOOP_DIRTY_RESULT_IN && SNOOP_HIT_OE_N
         && SNOOP_DIRTY_RESULT_OE_N;
   endsequence
   sequence s_dirty_req;
      $rose(SNOOP_REQ) && !SNOOP_BUSY && SNOOP_HIT_DIRTY;
   endsequence
   property p_dirty;
      s_dirty_req |=> !SNOOP_DIRTY_RESULT_OE_N && SNOOP_HIT_OE_N
         && SNOOP_DONE;
   endproperty
   a_dirty: assert property (p_dirty) else $error("dirty answer");
   property p_stall;
      SNOOP_REQ && SNOOP_BUSY |=> !SNOOP_HIT_OE_N && !SNOOP_DIRTY_RESULT_OE_N;
   endproperty
   a_stall: assert property (p_stall) else $error("no stall");
   property p_peer;
      s_peer_both [*4] |-> PEER_SNOOP_STALL && !PEER_SNOOP_VALID;
   endproperty
   a_peer: assert property (p_peer) else $error("stall decode");
   property p_fset;
      FAULT_DETECT && !restart |=> INTERNAL_FAULT_FLAG;
   endproperty
   a_fset: assert property (p_fset) else $error("fault not set");
   property p_fhold;
      $fell(INTERNAL_FAULT_FLAG) |-> $past(restart, 2) || $past(restart, 3);
   endproperty
   a_fhold: assert property (p_fhold) else $error("fault dropped");
   property p_warm;
      WARM_RESTART [*4] |-> INT_REG_CLEAR || SELFTEST_RUN;
   endproperty
   a_warm: assert property (p_warm) else $error("no warm clear");
   property p_astart;
      ATOMIC_START |=> !ATOMIC_HOLD_OE_N;
   endproperty
   a_astart: assert property (p_astart) else $error("no hold");
   property p_akeep;
      !ATOMIC_HOLD_OE_N && !ATOMIC_END |=> !ATOMIC_HOLD_OE_N;
   endproperty
   a_akeep: assert property (p_akeep) else $error("hold lost");
endmodule : csb_chk

// *** csb_peer.sv ***
// peer bus agent: snoop answers and priority bus request
`timescale 1ns/10ps
module csb_peer (
   // bus clock
   input  wire logic       clk,
   // bench commands and observed hold wire
   input  wire logic [1:0] res,
   input  wire logic       want,
   input  wire logic       hold_seen,
   // wire drives
   output logic      [1:0] drv,
   output logic            bus_req,
   output logic            owns
);
   always_ff @(posedge clk) begin
      drv     <= res;
      bus_req <= want;
      owns    <= want && !hold_seen;
   end
endmodule : csb_peer

// *** csb_pkg.sv ***
// constants and types for the cpu bus sideband control block
// Contract
// - agents report snoop outcome on hit signals
// - both results asserted together means snoop stall
// - fault flag holds until reset or restart
// - ignore input set skips pending fpu error
// - ignore clear: pending error faults next instruction
// - native fault mode bit disables ignore input
// - warm restart clears integer state only
// - warm restart resumes at configured reset vector
// - snoops still serviced during warm restart
// - warm restart sampled at reset release runs selftest
// - controller off: pins become maskable and unmaskable
// - local interrupt controller enabled after reset
// - interrupt inputs taken as asynchronous
// - owner holds atomic hold across whole sequence
package csb_pkg;
   localparam int SYNC_STAGES = 2;
   localparam logic [31:0] RESET_VECTOR_DEFAULT = 32'hFFFF_FFF0;
   localparam logic [1:0] SNOOP_NONE  = 2'h0;
   localparam logic [1:0] SNOOP_CLEAN = 2'h1;
   localparam logic [1:0] SNOOP_DIRTY = 2'h2;
   localparam logic [1:0] SNOOP_STALL = 2'h3;

   typedef enum logic [1:0] {
      CSB_RUN    = 2'b00,
      CSB_WARM   = 2'b01,
      CSB_SELFT  = 2'b10
   } csb_state_t;
endpackage : csb_pkg

// *** csb_sync.sv ***
// two-stage synchroniser for asynchronous inputs
`timescale 1ns/10ps
module csb_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : csb_sync

// *** csb_top.sv ***
// processor side sideband control: snoop, fault, fpu ignore, init, lint, lock
`timescale 1ns/10ps
module csb_top
   import csb_pkg::*;
#(
   parameter logic [31:0] RESET_VECTOR = RESET_VECTOR_DEFAULT
) (
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RSTN,
   // snoop result pins, active high inside, open drain style
   input  wire logic        SNOOP_HIT_IN,
   input  wire logic        SNOOP_DIRTY_RESULT_IN,
   output logic             SNOOP_HIT_OUT,
   output logic             SNOOP_HIT_OE_N,
   output logic             SNOOP_DIRTY_RESULT_OUT,
   output logic             SNOOP_DIRTY_RESULT_OE_N,
   // snoop request from the core side
   input  wire logic        SNOOP_REQ,
   input  wire logic        SNOOP_HIT_CLEAN,
   input  wire logic        SNOOP_HIT_DIRTY,
   input  wire logic        SNOOP_BUSY,
   output logic             SNOOP_DONE,
   output logic             PEER_SNOOP_STALL,
   output logic             PEER_SNOOP_VALID,
   output logic [1:0]       PEER_SNOOP_RESULT,
   // internal fault
   input  wire logic        FAULT_DETECT,
   input  wire logic        BUS_RESTART_REQUEST,
   output logic             INTERNAL_FAULT_FLAG,
   // numeric fault handling
   input  wire logic        NUMERIC_FAULT_IGNORE,
   input  wire logic        NATIVE_FPU_FAULT_MODE,
   input  wire logic        FPU_ERROR_SET,
   input  wire logic        FPU_ERROR_CLEAR,
   input  wire logic        FPU_NONCTRL_ISSUE,
   output logic             FPU_EXCEPTION,
   output logic             FPU_ERROR_PENDING,
   // warm restart
   input  wire logic        WARM_RESTART,
   output logic             INT_REG_CLEAR,
   output logic             FETCH_START,
   output logic [31:0]      FETCH_VECTOR,
   output logic             SELFTEST_RUN,
   input  wire logic        SELFTEST_DONE,
   // local interrupts
   input  wire logic [1:0]  LOCAL_INTERRUPT_PINS,
   input  wire logic        LIC_DISABLE,
   input  wire logic        LIC_DISABLE_WE,
   output logic             LIC_ENABLED,
   output logic             MASKABLE_INTERRUPT_LINE,
   output logic             UNMASKABLE_INTERRUPT_LINE,
   output logic [1:0]       LOCAL_INT_EVENT,
   // atomic sequence hold
   input  wire logic        ATOMIC_START,
   input  wire logic        ATOMIC_END,
   input  wire logic        ATOMIC_HOLD_IN,
   output logic             ATOMIC_HOLD_OUT,
   output logic             ATOMIC_HOLD_OE_N,
   input  wire logic        PRIORITY_AGENT_BUS_REQUEST,
   output logic             PRIORITY_GRANT_OK
);
   localparam int NSYNC = 8;
   localparam int REL_LAST = SYNC_STAGES + 1;
   localparam int REL_W = $clog2(REL_LAST + 1);

   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] async_s;
   logic             s_hit;
   logic             s_dirty;
   logic             s_ignore;
   logic             s_warm;
   logic             s_bus_restart_request;
   logic [1:0]       s_lint;
   logic             s_hold;
   csb_state_t       state;
   csb_state_t       next_state;
   logic [REL_W-1:0] rel_cnt;
   logic             rel_sample;
   logic             own_hold;
   logic             drive_hit;
   logic             drive_dirty;
   logic [1:0]       peer_res;
   logic             fault;
   logic             fpu_pend;

   assign async_in = {ATOMIC_HOLD_IN, LOCAL_INTERRUPT_PINS,
                      BUS_RESTART_REQUEST, WARM_RESTART,
                      NUMERIC_FAULT_IGNORE, SNOOP_DIRTY_RESULT_IN,
                      SNOOP_HIT_IN};

   csb_sync #(.WIDTH(NSYNC)) u_sync (
      .clk   (MCLK),
      .rst_n (RSTN),
      .d     (async_in),
      .q     (async_s)
   );

   assign s_hit    = async_s[0];
   assign s_dirty  = async_s[1];
   assign s_ignore = async_s[2];
   assign s_warm   = async_s[3];
   assign s_bus_restart_request  = async_s[4];
   assign s_lint   = async_s[6:5];
   assign s_hold   = async_s[7];

   // snoop response: stall while busy, else clean or dirty result
   // own drive also reaches the wire, so the decode below sees it too
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         drive_hit   <= 1'b0;
         drive_dirty <= 1'b0;
         SNOOP_DONE  <= 1'b0;
      end else begin
         SNOOP_DONE <= 1'b0;
         if (SNOOP_REQ && SNOOP_BUSY) begin
            drive_hit   <= 1'b1;
            drive_dirty <= 1'b1;
         end else if (SNOOP_REQ) begin
            drive_hit   <= SNOOP_HIT_CLEAN & ~SNOOP_HIT_DIRTY;
            drive_dirty <= SNOOP_HIT_DIRTY;
            SNOOP_DONE  <= 1'b1;
         end else begin
            drive_hit   <= 1'b0;
            drive_dirty <= 1'b0;
         end
      end
   end

   assign SNOOP_HIT_OUT           = 1'b0;
   assign SNOOP_DIRTY_RESULT_OUT  = 1'b0;
   assign SNOOP_HIT_OE_N          = ~drive_hit;
   assign SNOOP_DIRTY_RESULT_OE_N = ~drive_dirty;

   // both result wires at once is a stall, never a result
   function automatic logic is_stall(input logic [1:0] res);
      return (res == SNOOP_STALL);
   endfunction : is_stall

   // decode of the peer's snoop result
   assign peer_res = {s_dirty, s_hit};
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         PEER_SNOOP_STALL  <= 1'b0;
         PEER_SNOOP_VALID  <= 1'b0;
         PEER_SNOOP_RESULT <= SNOOP_NONE;
      end else begin
         PEER_SNOOP_STALL <= is_stall(peer_res);
         PEER_SNOOP_VALID <= !is_stall(peer_res);
         if (!is_stall(peer_res)) begin
            PEER_SNOOP_RESULT <= peer_res;
         end
      end
   end

   // internal fault flag is sticky until restart of any kind
   // a restart in the same cycle wins over a new fault
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         fault <= 1'b0;
      end else if (s_bus_restart_request || s_warm) begin
         fault <= 1'b0;
      end else if (FAULT_DETECT) begin
         fault <= 1'b1;
      end
   end
   assign INTERNAL_FAULT_FLAG = fault;

   // pending floating point error; a new error wins over a clear
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         fpu_pend <= 1'b0;
      end else if (FPU_ERROR_SET) begin
         fpu_pend <= 1'b1;
      end else if (FPU_ERROR_CLEAR) begin
         fpu_pend <= 1'b0;
      end
   end

   // exception on the next noncontrol instruction unless ignored
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         FPU_EXCEPTION <= 1'b0;
      end else begin
         FPU_EXCEPTION <= 1'b0;
         if (FPU_NONCTRL_ISSUE && (fpu_pend || FPU_ERROR_SET)) begin
            if (NATIVE_FPU_FAULT_MODE || !s_ignore) begin
               FPU_EXCEPTION <= 1'b1;
            end
         end
      end
   end
   assign FPU_ERROR_PENDING = fpu_pend;

   // warm restart and self test sequencing
   // the synchroniser is cleared by reset, so the pin level at release
   // reaches s_warm only SYNC_STAGES edges later; decide self test there
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         rel_cnt <= '0;
      end else if (rel_cnt != REL_W'(REL_LAST)) begin
         rel_cnt <= rel_cnt + 1'b1;
      end
   end
   assign rel_sample = (rel_cnt == REL_W'(SYNC_STAGES));

   always_comb begin
      next_state = state;
      case (state)
         CSB_RUN: begin
            if (rel_sample && s_warm) begin
               next_state = CSB_SELFT;
            end else if (s_warm) begin
               next_state = CSB_WARM;
            end
         end
         CSB_WARM: begin
            if (!s_warm) begin
               next_state = CSB_RUN;
            end
         end
         CSB_SELFT: begin
            if (SELFTEST_DONE) begin
               next_state = CSB_RUN;
            end
         end
         default: next_state = CSB_RUN;
      endcase
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         state <= CSB_RUN;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         INT_REG_CLEAR <= 1'b0;
         FETCH_START   <= 1'b0;
         FETCH_VECTOR  <= RESET_VECTOR;
         SELFTEST_RUN  <= 1'b0;
      end else begin
         INT_REG_CLEAR <= (next_state == CSB_WARM);
         SELFTEST_RUN  <= (next_state == CSB_SELFT);
         FETCH_START   <= (state != CSB_RUN) && (next_state == CSB_RUN);
         FETCH_VECTOR  <= RESET_VECTOR;
      end
   end

   // local interrupt controller enable, on by default
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         LIC_ENABLED <= 1'b1;
      end else if (LIC_DISABLE_WE) begin
         LIC_ENABLED <= ~LIC_DISABLE;
      end
   end

   // controller off: the pins act as plain interrupt lines
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         MASKABLE_INTERRUPT_LINE   <= 1'b0;
         UNMASKABLE_INTERRUPT_LINE <= 1'b0;
         LOCAL_INT_EVENT           <= 2'h0;
      end else if (LIC_ENABLED) begin
         MASKABLE_INTERRUPT_LINE   <= 1'b0;
         UNMASKABLE_INTERRUPT_LINE <= 1'b0;
         LOCAL_INT_EVENT           <= s_lint;
      end else begin
         MASKABLE_INTERRUPT_LINE   <= s_lint[0];
         UNMASKABLE_INTERRUPT_LINE <= s_lint[1];
         LOCAL_INT_EVENT           <= 2'h0;
      end
   end

   // atomic hold driven from a start until the first end after it
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         own_hold <= 1'b0;
      end else if (ATOMIC_START) begin
         own_hold <= 1'b1;
      end else if (ATOMIC_END) begin
         own_hold <= 1'b0;
      end
   end
   assign ATOMIC_HOLD_OUT  = 1'b0;
   assign ATOMIC_HOLD_OE_N = ~own_hold;

   // the peer may take the bus only once no hold is seen
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         PRIORITY_GRANT_OK <= 1'b0;
      end else begin
         PRIORITY_GRANT_OK <= PRIORITY_AGENT_BUS_REQUEST
                              && !s_hold && !own_hold;
      end
   end
endmodule : csb_top

// *** csb_top_test.sv ***
// self-checking testbench for the sideband control block
`timescale 1ns/10ps
module csb_top_test;
   import csb_pkg::*;
   localparam logic [31:0] RV = 32'h000F_FFF0;
   logic MCLK = 0, RSTN = 0, SNOOP_REQ = 0, SNOOP_HIT_CLEAN = 0;
   logic SNOOP_HIT_DIRTY = 0, SNOOP_BUSY = 0, FAULT_DETECT = 0;
   logic BUS_RESTART_REQUEST = 0, NUMERIC_FAULT_IGNORE = 0;
   logic NATIVE_FPU_FAULT_MODE = 0, FPU_ERROR_SET = 0, FPU_ERROR_CLEAR = 0;
   logic FPU_NONCTRL_ISSUE = 0, WARM_RESTART = 0, SELFTEST_DONE = 0;
   logic LIC_DISABLE = 0, LIC_DISABLE_WE = 0, ATOMIC_START = 0;
   logic ATOMIC_END = 0, want = 0, owns, PRIORITY_AGENT_BUS_REQUEST;
   logic [1:0] LOCAL_INTERRUPT_PINS = 2'h0, res = 2'h0, drv;
   logic SNOOP_HIT_IN, SNOOP_DIRTY_RESULT_IN, ATOMIC_HOLD_IN;
   logic SNOOP_HIT_OUT, SNOOP_HIT_OE_N, SNOOP_DIRTY_RESULT_OUT;
   logic SNOOP_DIRTY_RESULT_OE_N, SNOOP_DONE, PEER_SNOOP_STALL;
   logic PEER_SNOOP_VALID, INTERNAL_FAULT_FLAG, FPU_EXCEPTION;
   logic FPU_ERROR_PENDING, INT_REG_CLEAR, FETCH_START, SELFTEST_RUN;
   logic LIC_ENABLED, MASKABLE_INTERRUPT_LINE, UNMASKABLE_INTERRUPT_LINE;
   logic ATOMIC_HOLD_OUT, ATOMIC_HOLD_OE_N, PRIORITY_GRANT_OK;
   logic [1:0] PEER_SNOOP_RESULT, LOCAL_INT_EVENT;
   logic [31:0] FETCH_VECTOR;
   int n_errors = 0, cmp_count = 0, i;
   always #4 MCLK = ~MCLK;
   // open-drain wires: snoop wires asserted when either end pulls, hold wire by this end only
   assign SNOOP_HIT_IN = !SNOOP_HIT_OE_N | drv[0];
   assign SNOOP_DIRTY_RESULT_IN = !SNOOP_DIRTY_RESULT_OE_N | drv[1];
   assign ATOMIC_HOLD_IN = !ATOMIC_HOLD_OE_N;
   csb_top #(.RESET_VECTOR(RV)) dut_u (.*);
   csb_peer peer_u (.clk(MCLK), .res(res), .want(want),
      .hold_seen(ATOMIC_HOLD_IN), .drv(drv),
      .bus_req(PRIORITY_AGENT_BUS_REQUEST), .owns(owns));
   task chk(input logic c, input string m);
      cmp_count++;
      if (c !== 1'h1) begin
         n_errors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk
   task close_out;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out
   task tick(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask : tick
   task lim;
      if (i >= 50) begin
         chk(1'h0, "timeout");
         close_out;
      end
   endtask : lim
   task wait_fetch;
      for (i = 0; i < 50 && FETCH_START !== 1'h1; i++) tick(1);
      lim;
      chk(FETCH_VECTOR === RV, "vector");
   endtask : wait_fetch
   task snoop(input logic [1:0] k, input logic bz);
      @(posedge MCLK) SNOOP_REQ <= 1;
      SNOOP_HIT_CLEAN <= k[0];
      SNOOP_HIT_DIRTY <= k[1];
      SNOOP_BUSY <= bz;
      @(posedge MCLK) SNOOP_REQ <= 0;
      #1 chk({SNOOP_DIRTY_RESULT_OE_N, SNOOP_HIT_OE_N} === ~(k | {bz, bz})
         && SNOOP_DONE === ~bz && SNOOP_HIT_OUT === 1'h0
         && SNOOP_DIRTY_RESULT_OUT === 1'h0, "snoop");
      $display("snoop test done");
   endtask : snoop
   task peer;
      for (int k = 1; k < 4; k++) begin
         @(posedge MCLK) res <= 2'(k);
         tick(6);
         if (k == 3)
            chk(PEER_SNOOP_STALL === 1'h1
               && PEER_SNOOP_VALID === 1'h0, "stall");
         else
            chk(PEER_SNOOP_RESULT === 2'(k)
               && PEER_SNOOP_VALID === 1'h1, "result");
         @(posedge MCLK) res <= SNOOP_NONE;
         tick(6);
      end
      $display("peer test done");
   endtask : peer
   task fault(input logic bus);
      @(posedge MCLK) FAULT_DETECT <= 1;
      @(posedge MCLK) FAULT_DETECT <= 0;
      tick(8);
      chk(INTERNAL_FAULT_FLAG === 1'h1, "fault hold");
      @(posedge MCLK) BUS_RESTART_REQUEST <= bus;
      WARM_RESTART <= !bus;
      tick(5);
      chk(INTERNAL_FAULT_FLAG === 1'h0, "fault clear");
      @(posedge MCLK) BUS_RESTART_REQUEST <= 0;
      WARM_RESTART <= 0;
      tick(20);
      $display("fault test done");
   endtask : fault
   task fpu(input logic nfi, input logic nat, input logic exp);
      @(posedge MCLK) NUMERIC_FAULT_IGNORE <= nfi;
      NATIVE_FPU_FAULT_MODE <= nat;
      FPU_ERROR_SET <= 1;
      @(posedge MCLK) FPU_ERROR_SET <= 0;
      repeat (4) @(posedge MCLK);
      FPU_NONCTRL_ISSUE <= 1;
      @(posedge MCLK) FPU_NONCTRL_ISSUE <= 0;
      #1 chk(FPU_EXCEPTION === exp, "fpu");
      @(posedge MCLK) FPU_ERROR_CLEAR <= 1;
      @(posedge MCLK) FPU_ERROR_CLEAR <= 0;
      $display("fpu test done");
   endtask : fpu
   task lint;
      @(posedge MCLK) LOCAL_INTERRUPT_PINS <= 2'h3;
      tick(5);
      chk(LOCAL_INT_EVENT === 2'h3 && MASKABLE_INTERRUPT_LINE === 1'h0
         && UNMASKABLE_INTERRUPT_LINE === 1'h0, "lint on");
      @(posedge MCLK) LIC_DISABLE <= 1;
      LIC_DISABLE_WE <= 1;
      LOCAL_INTERRUPT_PINS <= 2'h0;
      @(posedge MCLK) LIC_DISABLE_WE <= 0;
      for (int k = 1; k < 3; k++) begin
         @(posedge MCLK) LOCAL_INTERRUPT_PINS <= 2'(k);
         tick(5);
         chk({UNMASKABLE_INTERRUPT_LINE, MASKABLE_INTERRUPT_LINE} === 2'(k)
            && LIC_ENABLED === 1'h0
            && LOCAL_INT_EVENT === 2'h0, "lint");
      end
      @(posedge MCLK) LOCAL_INTERRUPT_PINS <= 2'h0;
      LIC_DISABLE <= 0;
      $display("lint test done");
   endtask : lint
   task atomic;
      @(posedge MCLK) ATOMIC_START <= 1;
      want <= 1;
      @(posedge MCLK) ATOMIC_START <= 0;
      tick(6);
      chk(PRIORITY_GRANT_OK === 1'h0 && owns === 1'h0, "grant");
      chk(ATOMIC_HOLD_OE_N === 1'h0 && ATOMIC_HOLD_OUT === 1'h0, "hold");
      @(posedge MCLK) ATOMIC_END <= 1;
      @(posedge MCLK) ATOMIC_END <= 0;
      for (i = 0; i < 50 && PRIORITY_GRANT_OK !== 1'h1; i++) tick(1);
      lim;
      chk(ATOMIC_HOLD_OE_N === 1'h1
         && owns === 1'h1, "release");
      @(posedge MCLK) want <= 0;
      $display("atomic test done");
   endtask : atomic
   task warm;
      @(posedge MCLK) FPU_ERROR_SET <= 1;
      @(posedge MCLK) FPU_ERROR_SET <= 0;
      WARM_RESTART <= 1;
      tick(5);
      chk(INT_REG_CLEAR === 1'h1 && FPU_ERROR_PENDING === 1'h1, "warm");
      snoop(SNOOP_DIRTY, 0);
      @(posedge MCLK) WARM_RESTART <= 0;
      wait_fetch;
      $display("warm test done");
   endtask : warm
   task selftest;
      @(posedge MCLK) RSTN <= 0;
      WARM_RESTART <= 1;
      repeat (4) @(posedge MCLK);
      RSTN <= 1;
      repeat (2) @(posedge MCLK);
      WARM_RESTART <= 0;
      tick(1);
      chk(SELFTEST_RUN === 1'h1
         && LIC_ENABLED === 1'h1, "selftest");
      @(posedge MCLK) SELFTEST_DONE <= 1;
      wait_fetch;
      $display("selftest test done");
   endtask : selftest
   initial begin
      repeat (4) @(posedge MCLK);
      RSTN <= 1;
      tick(1);
      chk(LIC_ENABLED === 1'h1 && FETCH_VECTOR === RV, "reset");
      snoop(SNOOP_CLEAN, 0);
      snoop(SNOOP_DIRTY, 0);
      snoop(SNOOP_NONE, 1);
      peer;
      fault(1);
      fault(0);
      fpu(1, 0, 0);
      fpu(1, 1, 1);
      fpu(0, 0, 1);
      lint;
      atomic;
      warm;
      selftest;
      close_out;
   end
endmodule : csb_top_test
bind csb_top csb_chk chk_u (.*);
